// file: rtl/baud_timer_pkg.sv
// Constants, register map and carrier types for the capture/reload/baud timer.
// Assumes a 32-bit APB slave view with one register per aligned word.
package baud_timer_pkg;

    // Register byte addresses.
    localparam logic [11:0] MODE_CTRL_ADDR  = 12'h0c8;
    localparam logic [11:0] RELOAD_ADDR     = 12'h0cc;
    localparam logic [11:0] COUNT_ADDR      = 12'h0d0;
    localparam logic [11:0] DIVIDE_ADDR     = 12'h0d4;
    localparam logic [11:0] IRQ_STATUS_ADDR = 12'h0d8;
    localparam logic [11:0] IRQ_MASK_ADDR   = 12'h0dc;

    // Bit positions in timer_mode_control.
    localparam int OVF_FLAG_BIT   = 7;
    localparam int EXT_FLAG_BIT   = 6;
    localparam int RX_CLK_SEL_BIT = 5;
    localparam int TX_CLK_SEL_BIT = 4;
    localparam int EXT_TRIG_EN_BIT = 3;
    localparam int RUN_BIT        = 2;
    localparam int CNT_SRC_BIT    = 1;
    localparam int CAP_RLD_BIT    = 0;

    // Bit positions in the interrupt status and mask registers.
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_EXT_BIT = 1;

    // Reset values.
    localparam logic [7:0]  MODE_CTRL_RESET = 8'h00;
    localparam logic [15:0] WORD16_RESET    = 16'h0000;
    localparam logic [1:0]  IRQ_RESET       = 2'h0;
    localparam logic        DIV_SEL_RESET   = 1'b0;

    // Prescaler counts in system clock cycles, and the all-ones value of the counter.
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [3:0] DIV2_LAST  = 4'h1;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_CAPTURE,
        MODE_RELOAD,
        MODE_BAUD
    } timer_mode_e;

    // Pulses sent to the serial port shift-clock dividers.
    typedef struct packed {
        logic rx_tick;
        logic tx_tick;
    } uart_ticks_s;

endpackage

// file: rtl/baud_timer.sv
// Sixteen-bit capture / auto-reload / baud-rate timer with an APB register port.
// Assumes count and trigger pins already synchronous to CLOCK and an APB master.
// Behaviour
// [R01] Count source bit picks divided system clock or falling edges of count pin.
// [R02] Not baud and running: capture select 1 gives capture, 0 gives auto-reload.
// [R03] Counting happens only while the run bit is one.
// [R04] Capture mode trigger edge copies the count into the capture pair, sets external flag.
// [R05] Trigger enable zero makes trigger pin edges do nothing.
// [R06] In capture and reload modes wrap from all ones sets overflow flag.
// [R07] Auto-reload mode loads the reload pair into the counter on overflow.
// [R08] Auto-reload mode trigger edge forces reload and sets external flag.
// [R09] Either UART clock select bit forces auto-reload behaviour.
// [R10] Baud mode overflow sets no flag, pulses the UART shift clock instead.
// [R11] Baud mode internal clocking advances at half the system clock.
// [R12] Baud mode with count source set advances on count pin edges.
// [R13] Receive select routes this or the other timer overflow to receive clock.
// [R14] Transmit select routes this or the other timer overflow to transmit clock.
// [R15] Baud mode trigger edge sets external flag only, no capture or reload.
// [R16] Both flags request the shared interrupt; only software clears them.
// [R17] An output pulse can start an analog-to-digital conversion.
// [R18] Pins are resynchronised and falling edges become one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

module baud_timer
    import baud_timer_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    // External pins and the other timer
    input  wire logic        EXT_COUNT_PIN,
    input  wire logic        EXT_TRIGGER_PIN,
    input  wire logic        OTHER_TIMER_OVF,
    // Outputs
    output var  logic        UART_RX_TICK,
    output var  logic        UART_TX_TICK,
    output var  logic        ADC_START,
    output var  logic        IRQ
);

    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Pin synchronisers and falling-edge detection.
    logic [2:0] cnt_pin_r;
    logic [2:0] cnt_pin_nxt;
    logic [2:0] trg_pin_r;
    logic [2:0] trg_pin_nxt;
    logic       cnt_fall;
    logic       trg_fall;

    always_comb begin
        cnt_pin_nxt = {cnt_pin_r[1:0], EXT_COUNT_PIN};
        trg_pin_nxt = {trg_pin_r[1:0], EXT_TRIGGER_PIN};
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            cnt_pin_r <= 3'h7;
            trg_pin_r <= 3'h7;
        end else begin
            cnt_pin_r <= cnt_pin_nxt;
            trg_pin_r <= trg_pin_nxt;
        end
    end

    assign cnt_fall = cnt_pin_r[2] & ~cnt_pin_r[1]; // [R18]
    assign trg_fall = trg_pin_r[2] & ~trg_pin_r[1]; // [R18]

    // Registers and timer state.
    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic [15:0] reload_r;
    logic [15:0] reload_nxt;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic        div_sel_r;
    logic        div_sel_nxt;
    logic [1:0]  irq_stat_r;
    logic [1:0]  irq_stat_nxt;
    logic [1:0]  irq_mask_r;
    logic [1:0]  irq_mask_nxt;
    logic [3:0]  pre_r;
    logic [3:0]  pre_nxt;
    logic [31:0] prdata_nxt;
    logic        pready_nxt;
    logic        pslverr_nxt;
    uart_ticks_s ticks_nxt;
    logic        adc_nxt;
    logic        irq_nxt;

    timer_mode_e mode;
    logic        baud;
    logic        tick;
    logic        ovf;
    logic        ext_evt;
    logic        wr;
    logic        rd;
    logic        hit;
    logic [3:0]  pre_last;

    logic        wr_ctrl;
    logic        wr_reload;
    logic        wr_count;
    logic        wr_divide;
    logic        wr_status;
    logic        wr_mask;

    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] r);
        return a == r;
    endfunction

    // True for any offset that names a register of this block.
    function automatic logic addr_mapped(input logic [11:0] a);
        logic m;
        m = 1'b0;
        case (a)
            MODE_CTRL_ADDR:  m = 1'b1;
            RELOAD_ADDR:     m = 1'b1;
            COUNT_ADDR:      m = 1'b1;
            DIVIDE_ADDR:     m = 1'b1;
            IRQ_STATUS_ADDR: m = 1'b1;
            IRQ_MASK_ADDR:   m = 1'b1;
            default:         m = 1'b0;
        endcase
        return m;
    endfunction

    // Next counter value; shared by counting and by the same-edge capture.
    function automatic logic [15:0] incr16(input logic [15:0] v);
        return v + 16'h0001;
    endfunction

    // Read value of one register, zero-extended into the bus word.
    function automatic logic [31:0] read_word(input logic [11:0] a, input logic [7:0] c, input logic [15:0] rl,
                                              input logic [15:0] cn, input logic dv, input logic [1:0] st,
                                              input logic [1:0] mk);
        logic [31:0] w;
        w = 32'h0;
        case (a)
            MODE_CTRL_ADDR:  w[7:0]  = c;
            RELOAD_ADDR:     w[15:0] = rl;
            COUNT_ADDR:      w[15:0] = cn;
            DIVIDE_ADDR:     w[0]    = dv;
            IRQ_STATUS_ADDR: w[1:0]  = st;
            IRQ_MASK_ADDR:   w[1:0]  = mk;
            default:         w       = 32'h0;
        endcase
        return w;
    endfunction

    assign baud = ctrl_r[RX_CLK_SEL_BIT] | ctrl_r[TX_CLK_SEL_BIT];

    always_comb begin
        if (!ctrl_r[RUN_BIT]) begin
            mode = MODE_OFF; // [R03]
        end else if (baud) begin
            mode = MODE_BAUD; // [R09]
        end else if (ctrl_r[CAP_RLD_BIT]) begin
            mode = MODE_CAPTURE; // [R02]
        end else begin
            mode = MODE_RELOAD; // [R02]
        end
    end

    // Prescaler: divide by 2 in baud mode, else by 1 or 12.
    always_comb begin
        if (baud) begin
            pre_last = DIV2_LAST; // [R11]
        end else if (div_sel_r) begin
            pre_last = 4'h0;
        end else begin
            pre_last = DIV12_LAST;
        end
        pre_nxt = 4'h0;
        tick    = 1'b0;
        if (mode != MODE_OFF) begin
            if (ctrl_r[CNT_SRC_BIT]) begin
                tick = cnt_fall; // [R01] [R12]
            end else if (pre_r >= pre_last) begin
                tick = 1'b1; // [R01]
            end else begin
                pre_nxt = pre_r + 4'h1;
            end
        end
    end

    assign ovf     = tick & (count_r == COUNT_ALL_ONES);
    assign ext_evt = trg_fall & ctrl_r[EXT_TRIG_EN_BIT] & (mode != MODE_OFF); // [R05]

    assign wr  = PSEL & PENABLE & PWRITE;
    assign rd  = PSEL & PENABLE & ~PWRITE;
    assign hit = addr_mapped(PADDR);

    // One write strobe per register; an unmapped offset raises none of them.
    assign wr_ctrl   = wr & is_addr(PADDR, MODE_CTRL_ADDR);
    assign wr_reload = wr & is_addr(PADDR, RELOAD_ADDR);
    assign wr_count  = wr & is_addr(PADDR, COUNT_ADDR);
    assign wr_divide = wr & is_addr(PADDR, DIVIDE_ADDR);
    assign wr_status = wr & is_addr(PADDR, IRQ_STATUS_ADDR);
    assign wr_mask   = wr & is_addr(PADDR, IRQ_MASK_ADDR);

    always_comb begin
        ctrl_nxt     = ctrl_r;
        reload_nxt   = reload_r;
        count_nxt    = count_r;
        div_sel_nxt  = div_sel_r;
        irq_stat_nxt = irq_stat_r;
        irq_mask_nxt = irq_mask_r;
        // Software writes first, so hardware events below win over clears.
        if (wr_ctrl) begin
            ctrl_nxt = PWDATA[7:0]; // [R16]
        end
        if (wr_reload) begin
            reload_nxt = PWDATA[15:0];
        end
        if (wr_count) begin
            count_nxt = PWDATA[15:0];
        end
        if (wr_divide) begin
            div_sel_nxt = PWDATA[0];
        end
        if (wr_status) begin
            irq_stat_nxt = irq_stat_r & ~PWDATA[1:0];
        end
        if (wr_mask) begin
            irq_mask_nxt = PWDATA[1:0];
        end
        if (tick) begin
            count_nxt = incr16(count_r);
        end
        case (mode)
            MODE_CAPTURE: begin
                if (ovf) begin
                    ctrl_nxt[OVF_FLAG_BIT]   = 1'b1; // [R06]
                    irq_stat_nxt[IRQ_OVF_BIT] = 1'b1;
                end
                if (ext_evt) begin
                    reload_nxt = tick ? incr16(count_r) : count_r; // [R04]
                end
            end
            MODE_RELOAD: begin
                if (ovf) begin
                    count_nxt = reload_r; // [R07]
                    ctrl_nxt[OVF_FLAG_BIT]   = 1'b1; // [R06]
                    irq_stat_nxt[IRQ_OVF_BIT] = 1'b1;
                end
                if (ext_evt) begin
                    count_nxt = reload_r; // [R08]
                end
            end
            MODE_BAUD: begin
                if (ovf) begin
                    count_nxt = reload_r; // [R10]
                end
            end
            default: begin
            end
        endcase
        if (ext_evt) begin
            ctrl_nxt[EXT_FLAG_BIT]    = 1'b1; // [R04] [R08] [R15]
            irq_stat_nxt[IRQ_EXT_BIT] = 1'b1;
        end
    end

    // Outputs and the bus answer.
    always_comb begin
        ticks_nxt.rx_tick = ctrl_r[RX_CLK_SEL_BIT] ? (ovf & (mode == MODE_BAUD)) : OTHER_TIMER_OVF; // [R13]
        ticks_nxt.tx_tick = ctrl_r[TX_CLK_SEL_BIT] ? (ovf & (mode == MODE_BAUD)) : OTHER_TIMER_OVF; // [R14]
        adc_nxt = ovf; // [R17]
        // The line follows the sticky status bits, so only an unmasked pending event holds it high.
        irq_nxt = |(irq_stat_nxt & irq_mask_nxt); // [R16]
        pready_nxt  = PSEL & ~PENABLE;
        pslverr_nxt = PSEL & ~PENABLE & ~hit;
        prdata_nxt  = 32'h0;
        // Read data is taken in the setup cycle and held through the access cycle.
        if (PSEL && !PENABLE && !PWRITE) begin
            prdata_nxt = read_word(PADDR, ctrl_r, reload_r, count_r, div_sel_r, irq_stat_r, irq_mask_r);
        end else if (rd) begin
            prdata_nxt = PRDATA;
        end
    end

    // Timer and register state.
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r       <= MODE_CTRL_RESET;
            reload_r     <= WORD16_RESET;
            count_r      <= WORD16_RESET;
            div_sel_r    <= DIV_SEL_RESET;
            irq_stat_r   <= IRQ_RESET;
            irq_mask_r   <= IRQ_RESET;
            pre_r        <= 4'h0;
        end else begin
            ctrl_r       <= ctrl_nxt;
            reload_r     <= reload_nxt;
            count_r      <= count_nxt;
            div_sel_r    <= div_sel_nxt;
            irq_stat_r   <= irq_stat_nxt;
            irq_mask_r   <= irq_mask_nxt;
            pre_r        <= pre_nxt;
        end
    end

    // Registered outputs, so every top-level output comes from a flip-flop.
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA       <= 32'h0;
            PREADY       <= 1'b0;
            PSLVERR      <= 1'b0;
            UART_RX_TICK <= 1'b0;
            UART_TX_TICK <= 1'b0;
            ADC_START    <= 1'b0;
            IRQ          <= 1'b0;
        end else begin
            PRDATA       <= prdata_nxt;
            PREADY       <= pready_nxt;
            PSLVERR      <= pslverr_nxt;
            UART_RX_TICK <= ticks_nxt.rx_tick;
            UART_TX_TICK <= ticks_nxt.tx_tick;
            ADC_START    <= adc_nxt;
            IRQ          <= irq_nxt;
        end
    end

endmodule // baud_timer

`default_nettype wire

// file: test/baud_timer_checker.sv
// Assertions on the APB port and the pulse outputs of the timer.
// Assumes it is bound to the baud_timer top module.
`timescale 1ns/1ps
`default_nettype none
module baud_timer_checker
    import baud_timer_pkg::*;
(
    // Clock and reset
    input wire logic        CLOCK,
    input wire logic        RSTN,
    // APB
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // Pins and outputs
    input wire logic        OTHER_TIMER_OVF,
    input wire logic        UART_RX_TICK,
    input wire logic        UART_TX_TICK,
    input wire logic        ADC_START,
    input wire logic        IRQ
);
    logic [7:0] ctl_r;
    logic [7:0] ctl_nxt;
    logic       mapped;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    assign mapped = PADDR inside {MODE_CTRL_ADDR, RELOAD_ADDR, COUNT_ADDR, DIVIDE_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR};
    // Shadow of the control bits as software last wrote them.
    always_comb begin
        ctl_nxt = ctl_r;
        if (PSEL && PENABLE && PWRITE && PREADY && PADDR == MODE_CTRL_ADDR) begin
            ctl_nxt = PWDATA[7:0];
        end
    end
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ctl_r <= MODE_CTRL_RESET;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_access;
        s_setup ##1 PSEL && PENABLE;
    endsequence
    AST_APB_ZERO_WAIT: assert property (s_access |-> PREADY)
        else $error("ready missing in first access cycle");
    AST_APB_READY_ONE: assert property (PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");
    AST_APB_ERR_MAP: assert property (PREADY |-> PSLVERR == !mapped)
        else $error("error response does not match address map");
    AST_RX_ROUTE: assert property (!ctl_r[RX_CLK_SEL_BIT] |=> UART_RX_TICK == $past(OTHER_TIMER_OVF))
        else $error("receive tick not taken from other timer");
    AST_TX_ROUTE: assert property (!ctl_r[TX_CLK_SEL_BIT] |=> UART_TX_TICK == $past(OTHER_TIMER_OVF))
        else $error("transmit tick not taken from other timer");
    AST_IRQ_SW_CLEAR: assert property ($fell(IRQ) |-> $past(PWRITE && PREADY))
        else $error("interrupt dropped without a register write");
    AST_RUN_OFF_QUIET: assert property (!ctl_r[RUN_BIT] [*4] |-> !ADC_START)
        else $error("conversion start while timer stopped");
    AST_TICK_PULSE: assert property (ctl_r[RX_CLK_SEL_BIT] && UART_RX_TICK |=> !UART_RX_TICK)
        else $error("timer receive tick longer than one cycle");
endmodule // baud_timer_checker
bind baud_timer baud_timer_checker i_baud_timer_checker (.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .OTHER_TIMER_OVF(OTHER_TIMER_OVF), .UART_RX_TICK(UART_RX_TICK),
    .UART_TX_TICK(UART_TX_TICK), .ADC_START(ADC_START), .IRQ(IRQ));
`default_nettype wire

// file: test/timer_far_side.sv
// Far-side model: edge sources on the timer pins and counters of its output pulses.
// Assumes pins idle high; only falling edges carry events.
`timescale 1ns/1ps
`default_nettype none
module timer_far_side (
    // Clock
    input  wire logic clock,
    // Timer pulses
    input  wire logic rx_tick,
    input  wire logic tx_tick,
    input  wire logic adc_go,
    // Pins
    output var  logic count_pin,
    output var  logic trig_pin
);
    int n_rx = 0;
    int n_tx = 0;
    int n_adc = 0;
    initial count_pin = 1'b1;
    initial trig_pin = 1'b1;
    always @(posedge clock) begin
        n_rx += rx_tick;
        n_tx += tx_tick;
        n_adc += adc_go;
    end
    // Each pulse stays low three cycles and high four cycles before the next one, above the two-cycle minimum.
    task automatic pulse(input bit trig, input int n);
        repeat (n) begin
            @(posedge clock);
            if (trig) trig_pin <= 1'b0;
            else count_pin <= 1'b0;
            repeat (3) @(posedge clock);
            trig_pin <= 1'b1;
            count_pin <= 1'b1;
            repeat (3) @(posedge clock);
        end
    endtask
endmodule // timer_far_side
`default_nettype wire

// file: test/test_capture_reload_baud_timer.sv
// Self-checking bench: timer modes exercised through APB register accesses.
// Assumes the far-side model drives the pins and counts output pulses.
`timescale 1ns/1ps
`default_nettype none
module test_capture_reload_baud_timer
    import baud_timer_pkg::*;
;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        other_ovf = 1'b0;
    logic [31:0] rq;
    logic        re;
    int          n_errors = 0;
    int          n_compared = 0;
    int          r0;
    int          t0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, cnt_pin, trg_pin, rx_tick, tx_tick, adc_go, irq;
    always #5 clock = ~clock;
    baud_timer i_baud_timer (.CLOCK(clock), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EXT_COUNT_PIN(cnt_pin), .EXT_TRIGGER_PIN(trg_pin), .OTHER_TIMER_OVF(other_ovf),
        .UART_RX_TICK(rx_tick), .UART_TX_TICK(tx_tick), .ADC_START(adc_go), .IRQ(irq));
    timer_far_side i_timer_far_side (.clock(clock), .rx_tick(rx_tick), .tx_tick(tx_tick), .adc_go(adc_go),
        .count_pin(cnt_pin), .trig_pin(trg_pin));
    task automatic complete_run();
        if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            t++;
        end while (pready !== 1'b1 && t < 20);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) n_errors++;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        cmp($sformatf("reg %h", a), x & m, rq & m);
    endtask
    task automatic pin(input bit trig, input int n);
        i_timer_far_side.pulse(trig, n);
    endtask
    initial begin
        #200000;
        n_errors++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        rd(MODE_CTRL_ADDR, 32'h0, 32'hffffffff);
        rd(RELOAD_ADDR, 32'h0, 32'hffffffff);
        rd(COUNT_ADDR, 32'h0, 32'hffffffff);
        rd(DIVIDE_ADDR, 32'h0, 32'hffffffff);
        rd(IRQ_STATUS_ADDR, 32'h0, 32'hffffffff);
        rd(IRQ_MASK_ADDR, 32'h0, 32'hffffffff);
        rd(12'h0e0, 32'h0, 32'hffffffff);
        cmp("slverr", 32'h1, {31'h0, re});
        wr(MODE_CTRL_ADDR, 32'h04);
        repeat (120) @(posedge clock);
        wr(MODE_CTRL_ADDR, 32'h00);
        rd(COUNT_ADDR, 32'h0, 32'hfff0);
        wr(DIVIDE_ADDR, 32'h1);
        wr(RELOAD_ADDR, 32'hfff0);
        wr(COUNT_ADDR, 32'hfff8);
        wr(IRQ_MASK_ADDR, 32'h1);
        r0 = i_timer_far_side.n_adc;
        wr(MODE_CTRL_ADDR, 32'h04);
        repeat (40) @(posedge clock);
        rd(MODE_CTRL_ADDR, 32'h84, 32'hff);
        cmp("irq", 32'h1, {31'h0, irq});
        wr(MODE_CTRL_ADDR, 32'h00);
        rd(COUNT_ADDR, 32'hfff0, 32'hfff0);
        cmp("adc", 32'h1, {31'h0, i_timer_far_side.n_adc > r0});
        wr(IRQ_STATUS_ADDR, 32'h1);
        repeat (2) @(posedge clock);
        cmp("irq", 32'h0, {31'h0, irq});
        wr(COUNT_ADDR, 32'h1234);
        wr(MODE_CTRL_ADDR, 32'h0f);
        pin(1'b0, 5);
        pin(1'b1, 1);
        rd(RELOAD_ADDR, 32'h1239, 32'hffff);
        rd(MODE_CTRL_ADDR, 32'h4f, 32'hff);
        wr(MODE_CTRL_ADDR, 32'h0b);
        pin(1'b0, 5);
        rd(COUNT_ADDR, 32'h1239, 32'hffff);
        wr(MODE_CTRL_ADDR, 32'h07);
        pin(1'b0, 2);
        pin(1'b1, 1);
        rd(MODE_CTRL_ADDR, 32'h07, 32'hff);
        rd(RELOAD_ADDR, 32'h1239, 32'hffff);
        wr(RELOAD_ADDR, 32'h00a0);
        wr(COUNT_ADDR, 32'h0005);
        wr(MODE_CTRL_ADDR, 32'h0e);
        pin(1'b1, 1);
        rd(COUNT_ADDR, 32'h00a0, 32'hffff);
        rd(MODE_CTRL_ADDR, 32'h4e, 32'hff);
        wr(MODE_CTRL_ADDR, 32'h00);
        wr(RELOAD_ADDR, 32'hfffe);
        wr(COUNT_ADDR, 32'hfffe);
        wr(MODE_CTRL_ADDR, 32'h35);
        r0 = i_timer_far_side.n_rx;
        t0 = i_timer_far_side.n_tx;
        repeat (400) @(posedge clock);
        cmp("rx rate", 32'h1, {31'h0, (i_timer_far_side.n_rx - r0) inside {[99:101]}});
        cmp("tx rate", 32'h1, {31'h0, (i_timer_far_side.n_tx - t0) inside {[99:101]}});
        rd(MODE_CTRL_ADDR, 32'h35, 32'hff);
        wr(MODE_CTRL_ADDR, 32'h24);
        t0 = i_timer_far_side.n_tx;
        repeat (5) begin
            @(posedge clock);
            other_ovf <= 1'b1;
            @(posedge clock);
            other_ovf <= 1'b0;
            repeat (2) @(posedge clock);
        end
        cmp("tx other", 32'd5, i_timer_far_side.n_tx - t0);
        wr(MODE_CTRL_ADDR, 32'h00);
        wr(COUNT_ADDR, 32'hfffe);
        wr(MODE_CTRL_ADDR, 32'h36);
        t0 = i_timer_far_side.n_tx;
        pin(1'b0, 8);
        cmp("tx ext", 32'd4, i_timer_far_side.n_tx - t0);
        wr(MODE_CTRL_ADDR, 32'h00);
        wr(IRQ_STATUS_ADDR, 32'h3);
        wr(MODE_CTRL_ADDR, 32'h3c);
        pin(1'b1, 1);
        rd(MODE_CTRL_ADDR, 32'h7c, 32'hff);
        rd(RELOAD_ADDR, 32'hfffe, 32'hffff);
        rd(IRQ_STATUS_ADDR, 32'h2, 32'h3);
        wr(MODE_CTRL_ADDR, 32'h00);
        repeat (2) @(posedge clock);
        cmp("irq", 32'h0, {31'h0, irq});
        wr(IRQ_MASK_ADDR, 32'h2);
        repeat (2) @(posedge clock);
        cmp("irq", 32'h1, {31'h0, irq});
        wr(IRQ_STATUS_ADDR, 32'h2);
        repeat (2) @(posedge clock);
        cmp("irq", 32'h0, {31'h0, irq});
        complete_run();
    end
endmodule // test_capture_reload_baud_timer
`default_nettype wire
